// ===== hdl/dsp_spi_slave.v
// serial port of a quad potentiometer: pins, registers, wipers
`timescale 1ns/100ps
`include "dsp_consts.vh"
module dsp_spi_slave #(
  parameter TWC_CYC = `DSP_TWC_CYC
) (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // spi pins from the master
  input wire sck,
  input wire sdi,
  input wire cs_n,
  // sdo pin as two signals
  output reg sdo_o_q,
  output reg sdo_oe_q,
  // status
  output reg active_q,
  output reg wip_q,
  output reg shutdown_q,
  // wiper codes, 0 low terminal, 255 high terminal
  output reg [31:0] wiper_position_q
);
  // frame outline, as the logic sees it:
  // - select falls: counters start clean, stale data byte dropped
  // - first byte: three op bits, then five address bits
  // - later bytes: data, the last full one is kept
  // - read: the byte after the instruction leaves on sdo
  // - select rises: a pending write is carried out there
  // - nv write: busy flag and timer keep the port active
  //
  // pin handling:
  // - sck, sdi and select pass two flip-flops each
  // - sck edges found by comparing with one more stage
  // - link clock must stay slow against clk for this
  // - sdo bit changes just after a falling sck, and goes to 1 when deselected
  // - sdo enable low whenever select is high
  //
  // sdo driver types:
  // - push-pull: enable high for the whole selection
  // - open drain: enable high only for a low bit
  // - open drain never drives a high level, not even
  //   for one clock, so enable follows the next bit
  //
  // register side:
  // - control reg: volatile flag, shutdown flag, sdo type
  // - four wiper codes, code 0 near low_terminal
  // - code 255 near high_terminal
  // - four nv copies written when volatile flag is 0
  // - busy flag blocks writes and wiper reads
  // - reserved place reads as zero
  //
  // limits:
  // - writes without a full data byte are dropped
  // - general purpose places only start the busy time
  // - the wiper_terminal position is the code itself
  wire sck_s;
  wire sdi_s;
  wire cs_s;
  reg sck_d1_q;
  reg cs_d1_q;
  reg armed_q;
  reg [2:0] bit_q;
  reg [7:0] shin_q;
  reg [7:0] shout_q;
  reg [1:0] byte_q;
  reg [7:0] instr_q;
  reg [7:0] data_q;
  reg have_data_q;
  reg [7:0] access_control_reg;
  reg [31:0] ivr_q;
  reg [31:0] wip_cnt_q;
  reg [7:0] rd_val;
  reg [7:0] wr_byte_d;
  reg sdo_nxt;

  // pins pass two flip-flops first
  dsp_sync u_sck (.clk(clk), .rst(rst), .ce(ce), .pin(sck),
    .sync_q(sck_s));
  dsp_sync u_sdi (.clk(clk), .rst(rst), .ce(ce), .pin(sdi),
    .sync_q(sdi_s));
  dsp_sync u_cs (.clk(clk), .rst(rst), .ce(ce), .pin(~cs_n),
    .sync_q(cs_s));

  wire sck_rise = sck_s & ~sck_d1_q;
  wire sck_fall = ~sck_s & sck_d1_q;
  wire cs_fall = cs_s & ~cs_d1_q;
  wire cs_rise = ~cs_s & cs_d1_q;
  wire sel = cs_s & armed_q;
  wire [4:0] addr = instr_q[4:0];
  wire [2:0] op = instr_q[7:5];
  wire [7:0] shin_d = {shin_q[6:0], sdi_s};
  // first falling sck after the instruction byte of a read, and after each later byte
  wire sdo_load = (bit_q == 3'h0) && (byte_q == 2'h1) &&
    (op == `DSP_INSTR_READ);

  // next sdo bit: read byte msb on load, else shifter msb
  always @* begin
    sdo_nxt = sdo_o_q;
    if (sck_fall) begin
      if (sdo_load)
        sdo_nxt = rd_val[7];
      else
        sdo_nxt = shout_q[7];
    end
  end

  // read mux for the addressed register
  always @* begin
    rd_val = 8'h00;
    if (addr == `DSP_ADDR_ACR)
      rd_val = {access_control_reg[7:6], wip_q, 3'h0,
        access_control_reg[`DSP_ACR_SDO_BIT], 1'b0};
    else if (addr[4:2] == 3'h0 && !wip_q)
      rd_val = access_control_reg[`DSP_ACR_VOL_BIT] ?
        wiper_position_q[addr[1:0]*8 +: 8] : ivr_q[addr[1:0]*8 +: 8];
  end

  // shifter byte as it will be after this rising edge
  always @* begin
    wr_byte_d = shin_d;
  end

  // edge history
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d1_q <= 1'b0;
      cs_d1_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (ce) begin
      sck_d1_q <= sck_s;
      cs_d1_q <= cs_s;
      if (cs_fall)
        armed_q <= 1'b1;
    end
  end

  // serial shifting while selected
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_q <= 3'h0;
      shin_q <= 8'h00;
      shout_q <= 8'h00;
      byte_q <= 2'h0;
      instr_q <= 8'h00;
      data_q <= 8'h00;
      have_data_q <= 1'b0;
      sdo_o_q <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else if (ce) begin
      // every new selection drops a data byte left from before
      if (cs_fall)
        have_data_q <= 1'b0;
      if (!sel) begin
        bit_q <= 3'h0;
        byte_q <= 2'h0;
        sdo_oe_q <= 1'b0;
        sdo_o_q <= 1'b1;
      end else begin
        if (sck_rise) begin
          shin_q <= shin_d;
          bit_q <= bit_q + 3'h1;
          if (bit_q == `DSP_BIT_LAST) begin
            if (byte_q == 2'h0) begin
              instr_q <= wr_byte_d;
              byte_q <= 2'h1;
            end else begin
              data_q <= wr_byte_d;
              have_data_q <= 1'b1;
            end
          end
        end
        if (sck_fall) begin
          if (sdo_load)
            shout_q <= {rd_val[6:0], 1'b0};
          else
            shout_q <= {shout_q[6:0], 1'b0};
        end
        sdo_o_q <= sdo_nxt;
        // open drain drives only low, enable tracks next bit
        if (access_control_reg[`DSP_ACR_SDO_BIT])
          sdo_oe_q <= ~sdo_nxt;
        else
          sdo_oe_q <= 1'b1;
      end
    end
  end

  // write execution on select rise, nv write timer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      access_control_reg <= `DSP_ACR_RST;
      ivr_q <= {4{`DSP_WIPER_RST}};
      wiper_position_q <= {4{`DSP_WIPER_RST}};
      wip_q <= 1'b0;
      wip_cnt_q <= 32'h0;
      shutdown_q <= 1'b0;
      active_q <= 1'b0;
    end else if (ce) begin
      if (cs_rise && armed_q && have_data_q && op == `DSP_INSTR_WRITE
          && !wip_q) begin
        if (addr == `DSP_ADDR_ACR) begin
          access_control_reg[`DSP_ACR_VOL_BIT] <= data_q[7];
          access_control_reg[`DSP_ACR_SHDN_BIT] <= data_q[6];
          access_control_reg[`DSP_ACR_SDO_BIT] <= data_q[1];
        end else if (addr[4:2] == 3'h0) begin
          wiper_position_q[addr[1:0]*8 +: 8] <= data_q;
          if (!access_control_reg[`DSP_ACR_VOL_BIT]) begin
            ivr_q[addr[1:0]*8 +: 8] <= data_q;
            wip_q <= 1'b1;
            wip_cnt_q <= TWC_CYC;
          end
        end else if (addr != `DSP_ADDR_RSVD && !addr[4] &&
            !access_control_reg[`DSP_ACR_VOL_BIT]) begin
          wip_q <= 1'b1; // general purpose nv write
          wip_cnt_q <= TWC_CYC;
        end
      end else if (wip_q) begin
        if (wip_cnt_q <= 32'h1)
          wip_q <= 1'b0;
        wip_cnt_q <= wip_cnt_q - 32'h1;
      end
      shutdown_q <= ~access_control_reg[`DSP_ACR_SHDN_BIT];
      active_q <= sel | wip_q;
    end
  end
endmodule

// ===== pkg/dsp_consts.vh
// constants for the potentiometer serial port pin logic
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH
`define DSP_INSTR_WRITE 3'h3
`define DSP_INSTR_READ 3'h2
`define DSP_ADDR_ACR 5'h10
`define DSP_ADDR_RSVD 5'h0F
`define DSP_ACR_SDO_BIT 1
`define DSP_ACR_SHDN_BIT 6
`define DSP_ACR_VOL_BIT 7
`define DSP_ACR_RST 8'h40
`define DSP_WIPER_RST 8'h80
`define DSP_BIT_LAST 3'h7
`define DSP_TWC_MS 20
`define DSP_CLK_MHZ 250
`define DSP_TWC_CYC (`DSP_TWC_MS * 1000 * `DSP_CLK_MHZ)
`endif

// ===== hdl/dsp_sync.v
// two flip-flop synchroniser for one pin
`timescale 1ns/100ps
module dsp_sync (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // pin in, synchronised out
  input wire pin,
  output reg sync_q
);
  reg meta_q;

  // first stage only feeds second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end
endmodule

// ===== test/dsp_spi_slave_properties.sv
// checker for the serial port pins and status
`timescale 1ns/100ps
module dsp_chk (
  // clock, reset
  input wire clk,
  input wire rst,
  // pins, status
  input wire sck,
  input wire cs_n,
  input wire sdo_o_q,
  input wire sdo_oe_q,
  input wire active_q,
  input wire wip_q,
  input wire [31:0] wiper_position_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_d; cs_n [*8]; endsequence
  property p_hiz; s_d |-> !sdo_oe_q; endproperty
  a_hiz: assert property (p_hiz) else $error("sdo on");
  property p_act; $fell(cs_n) ##1 !cs_n [*7] |-> active_q; endproperty
  a_act: assert property (p_act) else $error("not active");
  property p_stb; s_d ##1 s_d ##0 !wip_q [*3] |-> !active_q; endproperty
  a_stb: assert property (p_stb) else $error("no standby");
  property p_wip; wip_q [*2] |-> active_q; endproperty
  a_wip: assert property (p_wip) else $error("idle in write");
  property p_upd; $changed(wiper_position_q) |-> cs_n; endproperty
  a_upd: assert property (p_upd) else $error("early wiper");
  property p_nvw; $rose(wip_q) |-> cs_n; endproperty
  a_nvw: assert property (p_nvw) else $error("early write");
  property p_out; !cs_n && $changed(sdo_o_q) |-> !sck; endproperty
  a_out: assert property (p_out) else $error("sdo on rise");
  property p_ign; s_d ##1 s_d |-> $stable(wiper_position_q); endproperty
  a_ign: assert property (p_ign) else $error("wiper moved");
endmodule

// ===== test/dsp_master.sv
// spi master model, mode 0
`timescale 1ns/100ps
module dsp_master (
  // serial pins
  output logic sck = 1'b0,
  output logic sdi = 1'b1,
  output logic cs_n = 1'b1,
  input wire sdo
);
  // one frame of two bytes, msb first
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    #2000 cs_n <= 1'b0;
    #300;
    for (int i = 15; i >= 0; i--) begin
      sdi <= tx[i];
      #62.5 sck <= 1'b1;
      rx = {rx[6:0], sdo};
      #62.5 sck <= 1'b0;
    end
    #300 cs_n <= 1'b1;
    sdi <= ~sdi;
  endtask
endmodule

// ===== test/tb.sv
// testbench for the serial port
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, rst = 1'b1;
  wire sck, sdi, cs_n, sdo_o_q, sdo_oe_q, active_q, wip_q, shutdown_q;
  wire [31:0] wiper_position_q;
  wire sdo = sdo_oe_q ? sdo_o_q : 1'b1; // pull-up
  logic [7:0] rx;
  int n_mismatch = 0, checked = 0;
  always #2 clk = ~clk;
  dsp_spi_slave #(.TWC_CYC(50)) dsp_spi_slave_inst (.clk, .rst, .ce(1'b1),
    .sck, .sdi, .cs_n, .sdo_o_q, .sdo_oe_q, .active_q, .wip_q, .shutdown_q,
    .wiper_position_q);
  dsp_master dsp_master_inst (.sck, .sdi, .cs_n, .sdo);
  task automatic chk(string n, logic [31:0] e, g);
    checked++;
    if (e !== g) $display("ERROR %s exp %h got %h", n, e, g);
    n_mismatch += (e !== g);
  endtask
  task automatic fr(logic [15:0] tx);
    dsp_master_inst.xfer(tx, rx);
    #40;
  endtask
  // nv write of wiper 0, busy window, then standby
  task automatic t_wr;
    fr(16'h60FF);
    chk("wiper0", 8'hFF, wiper_position_q[7:0]);
    chk("wip", 1'b1, wip_q);
    chk("sdo_oe", 1'b0, sdo_oe_q);
    #300;
    chk("active", 1'b0, active_q);
    $display("t_wr done");
  endtask
  // reads, reserved place, open drain volatile path
  task automatic t_rd;
    fr(16'h4000);
    chk("rd0", 8'hFF, rx);
    fr(16'h4F00);
    chk("rsvd", 8'h00, rx);
    fr(16'h7082);
    chk("shdn_on", 1'b1, shutdown_q);
    fr(16'h70C2);
    chk("shdn_off", 1'b0, shutdown_q);
    fr(16'h6155);
    chk("wiper1", 8'h55, wiper_position_q[15:8]);
    fr(16'h4100);
    chk("rd1", 8'h55, rx);
    $display("t_rd done");
  endtask
  task end_of_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_wr;
    t_rd;
    end_of_test;
  end
  initial begin
    #60000 n_mismatch++;
    end_of_test;
  end
endmodule
bind dsp_spi_slave dsp_chk dsp_chk_inst (.clk, .rst, .sck, .cs_n, .sdo_o_q,
  .sdo_oe_q, .active_q, .wip_q, .wiper_position_q);
